/* File: bench/profile_ctrl_model.sv */
`timescale 1ns/1ns

// external controller: moves the profile pins and serial lines only just
// after a clock edge, as a real sequencer clocked from the same source would
module profile_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] pins_req_i,
  input  wire logic [2:0] lines_req_i,
  output logic      [3:0] pins_o,
  output logic      [2:0] lines_o
);

  // serial lines carry ramp levels only, the port stays in one-bit mode;
  // outputs are unknown until the first edge, which falls inside reset
  always @(posedge clk_i) begin
    pins_o <= #1 pins_req_i;
    lines_o <= #1 lines_req_i;
  end

endmodule : profile_ctrl_model

/* File: bench/tb_profile_pin_modulation_router.sv */
`timescale 1ns/1ns

module tb_profile_pin_modulation_router;

  logic                                  clk_i = 1'b0;
  logic                                  reset_n_i = 1'b0;
  logic [3:0]                            pins_req = 4'h0;
  logic [2:0]                            lines_req = 3'h0;
  logic [3:0]                            pins;
  logic [2:0]                            lines;
  logic [1:0]                            lvl = 2'h0;
  logic [1:0]                            ramp = 2'h0;
  logic [2:0]                            cfg = 3'h0;
  logic [3:0][1:0]                       ty = '0;
  logic [3:0]                            sw = 4'h0;
  profile_route_pkg::chan_route_t [3:0]  chan_o;
  logic                                  single_o;
  int                                    n_mismatch = 0;
  int                                    tests_run = 0;

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  profile_ctrl_model u_profile_ctrl_model (
    .clk_i       (clk_i),
    .pins_req_i  (pins_req),
    .lines_req_i (lines_req),
    .pins_o      (pins),
    .lines_o     (lines)
  );

  // pins vector is {pin0,pin1,pin2,pin3}, lines is {line1,line2,line3}
  profile_pin_modulation_router u_profile_pin_modulation_router (
    .clk_i                      (clk_i),
    .reset_n_i                  (reset_n_i),
    .profile_pin_zero_i         (pins[3]),
    .profile_pin_one_i          (pins[2]),
    .profile_pin_two_i          (pins[1]),
    .profile_pin_three_i        (pins[0]),
    .serial_data_one_i          (lines[2]),
    .serial_data_two_i          (lines[1]),
    .serial_data_three_i        (lines[0]),
    .modulation_level_i         (lvl),
    .amplitude_ramp_updown_i    (ramp),
    .pin_channel_config_field_i (cfg),
    .modulation_type_select_i   (ty),
    .linear_sweep_enable_i      (sw),
    .chan_o                     (chan_o),
    .serial_single_bit_only_o   (single_o)
  );

  // reference routing, worked out independently of the design
  function automatic profile_route_pkg::chan_route_t [3:0] model_f(
    input logic [1:0] l, r, input logic [2:0] c,
    input logic [3:0][1:0] t, input logic [3:0] w, p, input logic [2:0] s);
    logic [5:0][3:0]                      pt;
    logic [3:0][3:0]                      ix;
    logic [3:0]                           rt, re, rd;
    logic [1:0]                           a, b, h;
    logic                                 ok;
    profile_route_pkg::chan_route_t [3:0] e;
    pt = {4'hB, 4'h7, 4'h6, 4'h3, 4'h2, 4'h1};
    ok = c <= profile_route_pkg::PAIR_CFG_LAST;
    a = ok ? pt[c][3:2] : 2'h0;
    b = ok ? pt[c][1:0] : 2'h0;
    h = c[1:0];
    ix = '0;
    rt = 4'h0;
    re = 4'h0;
    rd = 4'h0;
    case ({r, l})
      4'h0, 4'hC: begin
        for (int n = 0; n < 4; n++) begin
          ix[n] = {3'h0, p[3 - n]};
          rt[n] = 1'b1;
        end
        if (r != 2'h0) begin
          re[s[2:1]] = 1'b1;
          rd[s[2:1]] = s[0];
        end
      end
      4'h1, 4'hD: if (ok) begin
        ix[a] = {2'h0, p[3:2]};
        ix[b] = {2'h0, p[1:0]};
        rt[a] = 1'b1;
        rt[b] = 1'b1;
        re[a] = r != 2'h0;
        re[b] = r != 2'h0;
        rd[a] = r != 2'h0 && s[2];
        rd[b] = r != 2'h0 && s[1];
      end
      4'h2, 4'hA: begin
        ix[h] = {1'b0, p[3:1]};
        rt[h] = 1'b1;
        re[h] = r != 2'h0;
        rd[h] = r != 2'h0 && p[0];
      end
      4'h3, 4'hF: begin
        ix[h] = p;
        rt[h] = 1'b1;
        re[h] = r != 2'h0;
        rd[h] = r != 2'h0 && s[2];
      end
      4'h4: if (ok) begin
        ix[a] = {3'h0, p[3]};
        ix[b] = {3'h0, p[2]};
        rt[a] = 1'b1;
        rt[b] = 1'b1;
        re[a] = 1'b1;
        re[b] = 1'b1;
        rd[a] = p[1];
        rd[b] = p[0];
      end
      default: ;
    endcase
    for (int n = 0; n < 4; n++) begin
      e[n].active = rt[n] && t[n] != 2'h0 && !w[n];
      e[n].word_idx = ix[n];
      e[n].word_addr = ix[n] != 4'h0 ?
        profile_route_pkg::ADDR_CW_FIRST - 5'h01 + 5'(ix[n]) :
        t[n] == profile_route_pkg::MOD_AMPL ?
          profile_route_pkg::ADDR_AMPL_WORD :
        t[n] == profile_route_pkg::MOD_PHASE ?
          profile_route_pkg::ADDR_PHASE_WORD :
        profile_route_pkg::ADDR_FREQ_WORD;
      e[n].ramp_en = re[n];
      e[n].ramp_down = rd[n];
    end
    return e;
  endfunction : model_f

  task automatic check(input logic [63:0] seen, exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // unmodulated channels get type none; routed ones rotate through types
  task automatic run(input logic [1:0] l, r, input logic [2:0] c,
                     input logic [3:0] p, s4, w);
    profile_route_pkg::chan_route_t [3:0] e;
    logic [3:0][1:0]                      t;
    e = model_f(l, r, c, '1, 4'h0, p, s4[2:0]);
    for (int n = 0; n < 4; n++)
      t[n] = e[n].active ? 2'(c % 3 + 1) : 2'h0;
    @(posedge clk_i);
    #1;
    lvl = l;
    ramp = r;
    cfg = c;
    ty = t;
    sw = w;
    pins_req = p;
    lines_req = s4[2:0];
    // pins need one controller edge plus three design edges
    repeat (5) @(posedge clk_i);
    #1;
    e = model_f(l, r, c, t, w, p, s4[2:0]);
    check(64'(chan_o), 64'(e), "channel routing");
    check(64'(single_o), 64'(r == 2'h3), "serial width flag");
  endtask : run

  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    check(64'(chan_o), 64'h0, "outputs during reset");
    reset_n_i = 1'b1;
    run(2'h0, 2'h0, 3'h5, 4'hA, 4'h0, 4'h0);
    for (int c = 0; c < 6; c++)
      run(2'h1, 2'h0, 3'(c), 4'hD, 4'h0, 4'h0);
    run(2'h2, 2'h0, 3'h4, 4'hE, 4'h0, 4'h0);
    run(2'h2, 2'h0, 3'h2, 4'hF, 4'h0, 4'h0);
    for (int c = 0; c < 8; c++) begin
      run(2'h3, 2'h0, 3'(c), 4'hE, 4'h0, 4'h0);
      run(2'h3, 2'h0, 3'(c), 4'(c * 2 + 1), 4'h0, 4'h0);
      run(2'h3, 2'h0, 3'(c), 4'h0, 4'h0, 4'h0);
    end
    for (int c = 0; c < 6; c++) begin
      run(2'h0, 2'h1, 3'(c), 4'h9, 4'h0, 4'h0);
      run(2'h0, 2'h1, 3'(c), 4'h6, 4'h0, 4'h0);
      run(2'h1, 2'h3, 3'(c), 4'hD, 4'(c), 4'h0);
    end
    for (int c = 0; c < 4; c++) begin
      run(2'h2, 2'h2, 3'(c), 4'h7, 4'h0, 4'h0);
      run(2'h2, 2'h2, 3'(c + 4), 4'h6, 4'h0, 4'h0);
    end
    for (int s = 0; s < 8; s++)
      run(2'h0, 2'h3, 3'(s), 4'h5, 4'(s), 4'h0);
    run(2'h3, 2'h3, 3'h6, 4'hD, 4'h3, 4'h0);
    run(2'h3, 2'h3, 3'h1, 4'h2, 4'h4, 4'h0);
    // unsupported combinations route nothing
    run(2'h1, 2'h1, 3'h0, 4'hF, 4'h0, 4'h0);
    run(2'h3, 2'h2, 3'h1, 4'hF, 4'h0, 4'h0);
    run(2'h2, 2'h3, 3'h2, 4'hF, 4'h7, 4'h0);
    run(2'h1, 2'h0, 3'h6, 4'hF, 4'h0, 4'h0);
    run(2'h0, 2'h1, 3'h7, 4'hF, 4'h0, 4'h0);
    run(2'h1, 2'h3, 3'h6, 4'hF, 4'h7, 4'h0);
    // sweep on the chosen channel blocks direct modulation
    run(2'h3, 2'h0, 3'h1, 4'hE, 4'h0, 4'h2);
    // second reset in mid-run clears every output
    reset_n_i = 1'b0;
    #5;
    check(64'(chan_o), 64'h0, "outputs in second reset");
    @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    run(2'h3, 2'h0, 3'h3, 4'hE, 4'h0, 4'h0);
    results();
  end

endmodule : tb_profile_pin_modulation_router

/* File: design/profile_pin_modulation_router.sv */
`timescale 1ns/1ns

module profile_pin_modulation_router (
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   profile_pin_zero_i,
  input  wire logic                   profile_pin_one_i,
  input  wire logic                   profile_pin_two_i,
  input  wire logic                   profile_pin_three_i,
  input  wire logic                   serial_data_one_i,
  input  wire logic                   serial_data_two_i,
  input  wire logic                   serial_data_three_i,
  input  wire logic [1:0]             modulation_level_i,
  input  wire logic [1:0]             amplitude_ramp_updown_i,
  input  wire logic [2:0]             pin_channel_config_field_i,
  input  wire logic [3:0][1:0]        modulation_type_select_i,
  input  wire logic [3:0]             linear_sweep_enable_i,
  output profile_route_pkg::chan_route_t [3:0] chan_o,
  output logic                        serial_single_bit_only_o
);

  logic [3:0]                           pin_s1_ff;
  logic [3:0]                           pin_s2_ff;
  logic [2:0]                           ser_s1_ff;
  logic [2:0]                           ser_s2_ff;
  profile_route_pkg::chan_route_t [3:0] route_ff;
  profile_route_pkg::chan_route_t [3:0] nxt_route;
  logic                                 single_bit_ff;
  logic [3:0]                           routed;
  logic [3:0][3:0]                      idx;
  logic [3:0]                           ramp_en;
  logic [3:0]                           ramp_down;
  profile_route_pkg::chan_pair_t        pair;
  logic [1:0]                           one_ch;
  logic [3:0]                           p;
  logic [2:0]                           s;

  // channel pair for configuration codes 000..101
  function automatic profile_route_pkg::chan_pair_t pair_decode(
    input logic [2:0] cfg
  );
    profile_route_pkg::chan_pair_t r;
    r = '0;
    r.ok = 1'b1;
    case (cfg)
      3'h0: begin r.first = 2'h0; r.second = 2'h1; end
      3'h1: begin r.first = 2'h0; r.second = 2'h2; end
      3'h2: begin r.first = 2'h0; r.second = 2'h3; end
      3'h3: begin r.first = 2'h1; r.second = 2'h2; end
      3'h4: begin r.first = 2'h1; r.second = 2'h3; end
      3'h5: begin r.first = 2'h2; r.second = 2'h3; end
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction : pair_decode

  // word register address for an index and modulation type
  function automatic logic [4:0] word_addr_f(
    input logic [3:0] i,
    input logic [1:0] mod_type
  );
    logic [4:0] a;
    a = profile_route_pkg::ADDR_FREQ_WORD;
    if (i == 4'h0) begin
      if (mod_type == profile_route_pkg::MOD_AMPL) begin
        a = profile_route_pkg::ADDR_AMPL_WORD;
      end else if (mod_type == profile_route_pkg::MOD_PHASE) begin
        a = profile_route_pkg::ADDR_PHASE_WORD;
      end
    end else begin
      a = 5'(profile_route_pkg::ADDR_CW_FIRST + {1'b0, i} - 5'h01);
    end
    return a;
  endfunction : word_addr_f

  // pins are asynchronous to clk_i: two flops before any logic
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      ser_s1_ff <= 3'h0;
      ser_s2_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {profile_pin_three_i, profile_pin_two_i,
                    profile_pin_one_i, profile_pin_zero_i};
      pin_s2_ff <= pin_s1_ff;
      ser_s1_ff <= {serial_data_three_i, serial_data_two_i,
                    serial_data_one_i};
      ser_s2_ff <= ser_s1_ff;
    end
  end

  assign p      = pin_s2_ff;
  assign s      = ser_s2_ff;
  assign pair   = pair_decode(pin_channel_config_field_i);
  assign one_ch = pin_channel_config_field_i[1:0];

  // pin and serial-line assignment per mode
  always_comb begin
    routed    = 4'h0;
    idx       = '0;
    ramp_en   = 4'h0;
    ramp_down = 4'h0;
    case (amplitude_ramp_updown_i)
      profile_route_pkg::RAMP_OFF: begin
        case (modulation_level_i)
          profile_route_pkg::LVL_TWO: begin
            for (int c = 0; c < profile_route_pkg::NUM_CH; c++) begin
              routed[c] = 1'b1;
              idx[c]    = {3'h0, p[c]};
            end
          end
          profile_route_pkg::LVL_FOUR: begin
            if (pair.ok) begin
              routed[pair.first]  = 1'b1;
              routed[pair.second] = 1'b1;
              idx[pair.first]     = {2'h0, p[0], p[1]};
              idx[pair.second]    = {2'h0, p[2], p[3]};
            end
          end
          profile_route_pkg::LVL_EIGHT: begin
            routed[one_ch] = 1'b1;
            idx[one_ch]    = {1'b0, p[0], p[1], p[2]};
          end
          default: begin
            routed[one_ch] = 1'b1;
            idx[one_ch]    = {p[0], p[1], p[2], p[3]};
          end
        endcase
      end
      profile_route_pkg::RAMP_PINS_23: begin
        // other levels are not offered here and route nothing
        if (modulation_level_i == profile_route_pkg::LVL_TWO &&
            pair.ok) begin
          routed[pair.first]    = 1'b1;
          routed[pair.second]   = 1'b1;
          idx[pair.first]       = {3'h0, p[0]};
          idx[pair.second]      = {3'h0, p[1]};
          ramp_en[pair.first]   = 1'b1;
          ramp_en[pair.second]  = 1'b1;
          ramp_down[pair.first] = p[2];
          ramp_down[pair.second] = p[3];
        end
      end
      profile_route_pkg::RAMP_PIN_3: begin
        if (modulation_level_i == profile_route_pkg::LVL_EIGHT) begin
          routed[one_ch]    = 1'b1;
          idx[one_ch]       = {1'b0, p[0], p[1], p[2]};
          ramp_en[one_ch]   = 1'b1;
          ramp_down[one_ch] = p[3];
        end
      end
      default: begin
        case (modulation_level_i)
          profile_route_pkg::LVL_TWO: begin
            for (int c = 0; c < profile_route_pkg::NUM_CH; c++) begin
              routed[c] = 1'b1;
              idx[c]    = {3'h0, p[c]};
            end
            // lines 1,2 name the channel, line 3 the direction
            ramp_en[{s[0], s[1]}]   = 1'b1;
            ramp_down[{s[0], s[1]}] = s[2];
          end
          profile_route_pkg::LVL_FOUR: begin
            if (pair.ok) begin
              routed[pair.first]     = 1'b1;
              routed[pair.second]    = 1'b1;
              idx[pair.first]        = {2'h0, p[0], p[1]};
              idx[pair.second]       = {2'h0, p[2], p[3]};
              ramp_en[pair.first]    = 1'b1;
              ramp_en[pair.second]   = 1'b1;
              ramp_down[pair.first]  = s[0];
              ramp_down[pair.second] = s[1];
            end
          end
          profile_route_pkg::LVL_SIXTEEN: begin
            routed[one_ch]    = 1'b1;
            idx[one_ch]       = {p[0], p[1], p[2], p[3]};
            ramp_en[one_ch]   = 1'b1;
            ramp_down[one_ch] = s[0];
          end
          default: begin
            routed = 4'h0; // eight-level not offered with serial ramping
          end
        endcase
      end
    endcase
  end

  // a channel modulates only with a type chosen and sweep off
  always_comb begin
    for (int c = 0; c < profile_route_pkg::NUM_CH; c++) begin
      nxt_route[c].active    = routed[c] &
        (modulation_type_select_i[c] != profile_route_pkg::MOD_NONE) &
        ~linear_sweep_enable_i[c];
      nxt_route[c].word_idx  = idx[c];
      nxt_route[c].word_addr = word_addr_f(idx[c],
                                           modulation_type_select_i[c]);
      nxt_route[c].ramp_en   = ramp_en[c];
      nxt_route[c].ramp_down = ramp_down[c];
    end
  end

  // registered outputs keep glitches of the pin mux off the datapath
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      route_ff <= '0;
    end else begin
      route_ff <= nxt_route;
    end
  end

  // serial port restricted while its upper lines trigger ramps
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      single_bit_ff <= 1'b0;
    end else begin
      single_bit_ff <= (amplitude_ramp_updown_i ==
                        profile_route_pkg::RAMP_SERIAL);
    end
  end

  assign chan_o                   = route_ff;
  assign serial_single_bit_only_o = single_bit_ff;

  property p_eight_index;
    @(posedge clk_i) disable iff (!reset_n_i)
    (amplitude_ramp_updown_i == profile_route_pkg::RAMP_OFF &&
     modulation_level_i == profile_route_pkg::LVL_EIGHT)
    |=> chan_o[$past(one_ch)].word_idx == {1'b0, $past(p[0]),
        $past(p[1]), $past(p[2])};
  endproperty
  a_eight_index: assert property (p_eight_index)
    else $error("eight-level index not taken from pins zero to two");

  property p_sixteen_msb;
    @(posedge clk_i) disable iff (!reset_n_i)
    (amplitude_ramp_updown_i == profile_route_pkg::RAMP_OFF &&
     modulation_level_i == profile_route_pkg::LVL_SIXTEEN && p[0])
    |=> chan_o[$past(one_ch)].word_idx[3];
  endproperty
  a_sixteen_msb: assert property (p_sixteen_msb)
    else $error("pin zero is not the index msb");

  property p_pins23_level;
    @(posedge clk_i) disable iff (!reset_n_i)
    (amplitude_ramp_updown_i == profile_route_pkg::RAMP_PINS_23 &&
     modulation_level_i != profile_route_pkg::LVL_TWO)
    |=> chan_o[0].word_idx == 4'h0 && chan_o[3].ramp_en == 1'b0;
  endproperty
  a_pins23_level: assert property (p_pins23_level)
    else $error("ramp pins 2,3 mode routed a non two-level setting");

  property p_pair_ramp;
    @(posedge clk_i) disable iff (!reset_n_i)
    (amplitude_ramp_updown_i == profile_route_pkg::RAMP_PINS_23 &&
     modulation_level_i == profile_route_pkg::LVL_TWO && pair.ok)
    |=> chan_o[$past(pair.second)].ramp_en &&
        chan_o[$past(pair.second)].ramp_down == $past(p[3]);
  endproperty
  a_pair_ramp: assert property (p_pair_ramp)
    else $error("pin three does not ramp the second channel of the pair");

  property p_pin3_ramp;
    @(posedge clk_i) disable iff (!reset_n_i)
    (amplitude_ramp_updown_i == profile_route_pkg::RAMP_PIN_3 &&
     modulation_level_i == profile_route_pkg::LVL_EIGHT)
    |=> chan_o[$past(one_ch)].ramp_en &&
        chan_o[$past(one_ch)].ramp_down == $past(p[3]);
  endproperty
  a_pin3_ramp: assert property (p_pin3_ramp)
    else $error("pin three does not ramp the eight-level channel");

  property p_serial_flag;
    @(posedge clk_i) disable iff (!reset_n_i)
    $changed(amplitude_ramp_updown_i) |=> serial_single_bit_only_o ==
      ($past(amplitude_ramp_updown_i) == profile_route_pkg::RAMP_SERIAL);
  endproperty
  a_serial_flag: assert property (p_serial_flag)
    else $error("single-bit flag does not follow ramp assignment");

  property p_serial_dir;
    @(posedge clk_i) disable iff (!reset_n_i)
    (amplitude_ramp_updown_i == profile_route_pkg::RAMP_SERIAL &&
     modulation_level_i == profile_route_pkg::LVL_TWO)
    |=> chan_o[{$past(s[0]), $past(s[1])}].ramp_down == $past(s[2]);
  endproperty
  a_serial_dir: assert property (p_serial_dir)
    else $error("serial ramp direction wrong");

  property p_addr_range;
    @(posedge clk_i) disable iff (!reset_n_i)
    chan_o[2].word_idx != 4'h0 |->
      chan_o[2].word_addr == 5'(profile_route_pkg::ADDR_CW_FIRST +
        {1'b0, chan_o[2].word_idx} - 5'h01);
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("profile word address does not match index");

endmodule : profile_pin_modulation_router

/* File: inc/profile_route_pkg.sv */
package profile_route_pkg;

  // modulation level codes
  localparam logic [1:0] LVL_TWO       = 2'h0;
  localparam logic [1:0] LVL_FOUR      = 2'h1;
  localparam logic [1:0] LVL_EIGHT     = 2'h2;
  localparam logic [1:0] LVL_SIXTEEN   = 2'h3;

  // ramp pin assignment codes
  localparam logic [1:0] RAMP_OFF      = 2'h0;
  localparam logic [1:0] RAMP_PINS_23  = 2'h1;
  localparam logic [1:0] RAMP_PIN_3    = 2'h2;
  localparam logic [1:0] RAMP_SERIAL   = 2'h3;

  // modulation type codes
  localparam logic [1:0] MOD_NONE      = 2'h0;
  localparam logic [1:0] MOD_AMPL      = 2'h1;
  localparam logic [1:0] MOD_FREQ      = 2'h2;
  localparam logic [1:0] MOD_PHASE     = 2'h3;

  // word register addresses
  localparam logic [4:0] ADDR_FREQ_WORD  = 5'h04;
  localparam logic [4:0] ADDR_PHASE_WORD = 5'h05;
  localparam logic [4:0] ADDR_AMPL_WORD  = 5'h06;
  localparam logic [4:0] ADDR_CW_FIRST   = 5'h0A;
  localparam logic [4:0] ADDR_CW_LAST    = 5'h18;

  // highest channel-pair configuration code
  localparam logic [2:0] PAIR_CFG_LAST = 3'h5;

  localparam int NUM_CH   = 4;
  localparam int NUM_PINS = 4;

  // routing result for one channel
  typedef struct packed {
    logic       active;
    logic [3:0] word_idx;
    logic [4:0] word_addr;
    logic       ramp_en;
    logic       ramp_down;
  } chan_route_t;

  // channel pair decoded from the pin configuration field
  typedef struct packed {
    logic       ok;
    logic [1:0] first;
    logic [1:0] second;
  } chan_pair_t;

endpackage : profile_route_pkg
